// File: logic/lcdsd_button.sv
`include "lcdsd_map.svh"
module lcdsd_button #(
  parameter int unsigned DEBOUNCE_CYC = `LCDSD_DEBOUNCE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic button_in,
  output logic level_out,
  output logic press_out
);
  lcdsd_pkg::lcdsd_btn_t r_q, r_d;
  // ****************************************
  // synchronise, debounce, press edge
  // ****************************************
  always_comb begin
    r_d = r_q;
    r_d.sync = {r_q.sync[0], button_in};
    r_d.pulse = 1'b0;
    if (r_q.sync[1] != r_q.level) begin // RULE12
      if (r_q.cnt >= DEBOUNCE_CYC - 1) begin
        r_d.level = r_q.sync[1];
        r_d.cnt = 32'h0;
        if (r_q.sync[1]) begin
          r_d.pulse = 1'b1;
        end
      end else begin
        r_d.cnt = r_q.cnt + 32'h1;
      end
    end else begin
      r_d.cnt = 32'h0;
    end
    case (r_q.st)
      lcdsd_pkg::ST_IDLE: if (r_d.pulse) r_d.st = lcdsd_pkg::ST_HELD;
      lcdsd_pkg::ST_HELD: if (!r_d.level) r_d.st = lcdsd_pkg::ST_IDLE;
      default: r_d.st = lcdsd_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
  assign level_out = r_q.level;
  assign press_out = r_q.pulse;
endmodule

// File: logic/lcdsd_map.svh
`ifndef LCDSD_MAP_SVH
`define LCDSD_MAP_SVH
`define LCDSD_CLK_HZ 250000000
`define LCDSD_BP_HZ 100
`define LCDSD_TEST_HZ 1
`define LCDSD_BP_HALF (`LCDSD_CLK_HZ / (2 * `LCDSD_BP_HZ))
`define LCDSD_TEST_HALF (`LCDSD_CLK_HZ / (2 * `LCDSD_TEST_HZ))
`define LCDSD_DEBOUNCE_MS 10
`define LCDSD_DEBOUNCE_CYC (`LCDSD_CLK_HZ / 1000 * `LCDSD_DEBOUNCE_MS)
`define LCDSD_STEP_HZ 4
`define LCDSD_STEP_CYC (`LCDSD_CLK_HZ / `LCDSD_STEP_HZ)
`define LCDSD_NSEG 16
`define LCDSD_PAT_RST 16'h0001
`endif

// File: logic/lcdsd_pkg.sv
package lcdsd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PRESS, ST_HELD} lcdsd_btn_st_t;
  typedef struct packed {
    logic [1:0] sync;
    logic level;
    logic [31:0] cnt;
    lcdsd_btn_st_t st;
    logic pulse;
  } lcdsd_btn_t;
endpackage

// File: logic/lcdsd_top.sv
// Behaviour
// RULE1 - backplane 100 Hz square wave, 50 percent
// RULE2 - every segment has its own output pin
// RULE3 - lit segment drives inverted backplane
// RULE4 - blank segment drives same as backplane
// RULE5 - divider gives 1 Hz square output
// RULE6 - plain input copied straight to output
// RULE7 - hysteresis input copied straight to output
// RULE8 - shift register sets scroll step rate; code sets it with the step_cnt counter, pat only rotates
// RULE9 - toggle button swaps clock source, precision first
// RULE10 - reset button blanks, resets, selects precision
// RULE11 - rc source adds slowing delay stage
// RULE12 - buttons debounced, clock switching glitch free
`include "lcdsd_map.svh"
module lcdsd_top #(
  parameter int unsigned BP_HALF = `LCDSD_BP_HALF,
  parameter int unsigned TEST_HALF = `LCDSD_TEST_HALF,
  parameter int unsigned STEP_CYC = `LCDSD_STEP_CYC,
  parameter int unsigned DEBOUNCE_CYC = `LCDSD_DEBOUNCE_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic RESET_BUTTON_IN,
  input wire logic CLOCK_TOGGLE_BUTTON_IN,
  input wire logic PLAIN_IN,
  input wire logic HYST_IN,
  output logic LCD_BACKPLANE_OUT,
  output logic [`LCDSD_NSEG-1:0] SEGMENT_OUT,
  output logic ONE_HERTZ_OUTPUT_OUT,
  output logic PLAIN_BUF_OUT,
  output logic HYST_BUF_OUT,
  output logic RC_SELECT_OUT
);
  typedef struct packed {
    logic [31:0] bp_cnt;
    logic bp;
    logic [31:0] hz_cnt;
    logic hz;
    logic [31:0] step_cnt;
    logic slow;
    logic [`LCDSD_NSEG-1:0] pat;
    logic [`LCDSD_NSEG-1:0] seg;
    logic rc_sel;
    logic [1:0] plain_s;
    logic [1:0] hyst_s;
  } lcdsd_top_t;
  lcdsd_top_t s_q, s_d;
  logic rb_level;
  logic tog_press;
  logic blank;
  // ****************************************
  // push buttons
  // ****************************************
  lcdsd_button #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_rst_btn (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .button_in(RESET_BUTTON_IN),
    .level_out(rb_level),
    .press_out()
  );
  lcdsd_button #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_tog_btn (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .button_in(CLOCK_TOGGLE_BUTTON_IN),
    .level_out(),
    .press_out(tog_press)
  );
  assign blank = rb_level; // RULE10
  // ****************************************
  // dividers, scroll and segment drive
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.plain_s = {s_q.plain_s[0], PLAIN_IN};
    s_d.hyst_s = {s_q.hyst_s[0], HYST_IN};
    if (s_q.bp_cnt >= BP_HALF - 1) begin // RULE1
      s_d.bp_cnt = 32'h0;
      s_d.bp = ~s_q.bp;
    end else begin
      s_d.bp_cnt = s_q.bp_cnt + 32'h1;
    end
    if (s_q.hz_cnt >= TEST_HALF - 1) begin // RULE5
      s_d.hz_cnt = 32'h0;
      s_d.hz = ~s_q.hz;
    end else begin
      s_d.hz_cnt = s_q.hz_cnt + 32'h1;
    end
    if (tog_press) begin // RULE9
      s_d.rc_sel = ~s_q.rc_sel;
    end
    if (s_q.step_cnt >= STEP_CYC - 1) begin
      s_d.step_cnt = 32'h0;
      if (s_q.rc_sel && !s_q.slow) begin // RULE11
        s_d.slow = 1'b1;
      end else begin
        s_d.slow = 1'b0;
        s_d.pat = {s_q.pat[`LCDSD_NSEG-2:0], s_q.pat[`LCDSD_NSEG-1]}; // RULE8
      end
    end else begin
      s_d.step_cnt = s_q.step_cnt + 32'h1;
    end
    for (int i = 0; i < `LCDSD_NSEG; i++) begin // RULE2
      if (s_q.pat[i] && !blank) begin
        s_d.seg[i] = ~s_d.bp; // RULE3
      end else begin
        s_d.seg[i] = s_d.bp; // RULE4
      end
    end
    if (blank) begin // RULE10
      s_d.rc_sel = 1'b0;
      s_d.pat = `LCDSD_PAT_RST;
      s_d.step_cnt = 32'h0;
      s_d.slow = 1'b0;
    end
  end
  always_ff @(posedge CLOCK_IN) begin
    if (SYS_RST_IN) begin
      s_q <= '0;
      s_q.pat <= `LCDSD_PAT_RST;
    end else begin
      s_q <= s_d;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign LCD_BACKPLANE_OUT = s_q.bp;
  assign SEGMENT_OUT = s_q.seg;
  assign ONE_HERTZ_OUTPUT_OUT = s_q.hz;
  assign PLAIN_BUF_OUT = s_q.plain_s[1]; // RULE6
  assign HYST_BUF_OUT = s_q.hyst_s[1]; // RULE7
  assign RC_SELECT_OUT = s_q.rc_sel; // RULE12
endmodule

// File: tb/lcdsd_glass.sv
module lcdsd_glass (
  input wire logic bp_in,
  input wire logic [15:0] seg_in,
  output logic [15:0] lit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // a segment is dark only while it follows the backplane
  assign lit_out = seg_in ^ {16{bp_in}};
endmodule

// File: tb/lcdsd_top_properties.sv
module lcdsd_checker (
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic RESET_BUTTON_IN,
  input wire logic CLOCK_TOGGLE_BUTTON_IN,
  input wire logic PLAIN_IN,
  input wire logic HYST_IN,
  input wire logic LCD_BACKPLANE_OUT,
  input wire logic [15:0] SEGMENT_OUT,
  input wire logic ONE_HERTZ_OUTPUT_OUT,
  input wire logic PLAIN_BUF_OUT,
  input wire logic HYST_BUF_OUT,
  input wire logic RC_SELECT_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);
  property p_bp_hi; $rose(LCD_BACKPLANE_OUT) |=> LCD_BACKPLANE_OUT[*3] ##1 !LCD_BACKPLANE_OUT;
  endproperty
  a_bp_hi: assert property (p_bp_hi) else $error("bp high");
  property p_bp_lo; $fell(LCD_BACKPLANE_OUT) |=> !LCD_BACKPLANE_OUT[*3] ##1 LCD_BACKPLANE_OUT;
  endproperty
  a_bp_lo: assert property (p_bp_lo) else $error("bp low");
  property p_lit; $onehot0(SEGMENT_OUT ^ {16{LCD_BACKPLANE_OUT}}); endproperty
  a_lit: assert property (p_lit) else $error("seg phase");
  property p_hz; $rose(ONE_HERTZ_OUTPUT_OUT) |=> ONE_HERTZ_OUTPUT_OUT[*8] ##1
    ONE_HERTZ_OUTPUT_OUT[*7] ##1 !ONE_HERTZ_OUTPUT_OUT; endproperty
  a_hz: assert property (p_hz) else $error("1hz");
  property p_pl; !$past(SYS_RST_IN) && !$past(SYS_RST_IN, 2) |->
    PLAIN_BUF_OUT == $past(PLAIN_IN, 2); endproperty
  a_pl: assert property (p_pl) else $error("plain");
  property p_hy; !$past(SYS_RST_IN) && !$past(SYS_RST_IN, 2) |->
    HYST_BUF_OUT == $past(HYST_IN, 2); endproperty
  a_hy: assert property (p_hy) else $error("hyst");
  property p_tg; $rose(RC_SELECT_OUT) |-> $past(CLOCK_TOGGLE_BUTTON_IN, 5); endproperty
  a_tg: assert property (p_tg) else $error("toggle");
  property p_rb; RESET_BUTTON_IN[*8] |-> ##1
    (SEGMENT_OUT == {16{LCD_BACKPLANE_OUT}} && !RC_SELECT_OUT); endproperty
  a_rb: assert property (p_rb) else $error("blank");
endmodule
bind lcdsd_top lcdsd_checker lcdsd_checker_inst (.CLOCK_IN, .SYS_RST_IN, .RESET_BUTTON_IN,
  .CLOCK_TOGGLE_BUTTON_IN, .PLAIN_IN, .HYST_IN, .LCD_BACKPLANE_OUT, .SEGMENT_OUT,
  .ONE_HERTZ_OUTPUT_OUT, .PLAIN_BUF_OUT, .HYST_BUF_OUT, .RC_SELECT_OUT);

// File: tb/lcdsd_top_test.sv
module lcdsd_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, rb = 0, tg = 0, pi = 0, hi = 0, bp, one, pb, hb, rc;
  logic [15:0] seg, lit, prev;
  logic [3:0] h = 0;
  int n_fail = 0, num_checks = 0, cyc = 0, gap;
  lcdsd_top #(.BP_HALF(4), .TEST_HALF(16), .STEP_CYC(8), .DEBOUNCE_CYC(3)) lcdsd_top_inst (
    .CLOCK_IN(clk), .SYS_RST_IN(rst), .RESET_BUTTON_IN(rb), .CLOCK_TOGGLE_BUTTON_IN(tg),
    .PLAIN_IN(pi), .HYST_IN(hi), .LCD_BACKPLANE_OUT(bp), .SEGMENT_OUT(seg),
    .ONE_HERTZ_OUTPUT_OUT(one), .PLAIN_BUF_OUT(pb), .HYST_BUF_OUT(hb), .RC_SELECT_OUT(rc));
  lcdsd_glass lcdsd_glass_inst (.bp_in(bp), .seg_in(seg), .lit_out(lit));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (++cyc > 3000) begin
    n_fail++;
    complete_run();
  end
  task automatic complete_run();
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] step_gap(logic r);
    return r ? 16'h0010 : 16'h0008;
  endfunction
  task automatic scroll(logic r);
    prev = lit;
    repeat (20) if (lit === prev) @(negedge clk);
    prev = lit;
    gap = 0;
    while (lit === prev && gap < 40) begin
      @(negedge clk);
      gap++;
    end
    chk("gap", step_gap(r), 16'(gap));
    chk("rot", {prev[14:0], prev[15]}, lit);
  endtask
  task automatic half_period(ref logic s, input int e);
    logic v;
    v = s;
    gap = 0;
    while (s === v && gap < 100) begin
      @(negedge clk);
      gap++;
    end
    v = s;
    gap = 0;
    while (s === v && gap < 100) begin
      @(negedge clk);
      gap++;
    end
    chk("half", 16'(e), 16'(gap));
  endtask
  task automatic press(ref logic b, input int n);
    b = 1;
    repeat (n) @(negedge clk);
    b = 0;
    repeat (12) @(negedge clk);
  endtask
  initial begin
    void'($urandom(45063));
    repeat (6) @(negedge clk);
    rst = 0;
    repeat (200) begin
      @(negedge clk);
      chk("buf", 16'(h[3:2]), 16'({pb, hb}));
      {pi, hi} = 2'($urandom);
      h = {h[1:0], pi, hi};
    end
    half_period(bp, 4);
    half_period(one, 16);
    scroll(0);
    press(tg, 12 + $urandom % 10);
    chk("rc", 16'h0001, 16'(rc));
    scroll(1);
    press(tg, 2);
    chk("rc", 16'h0001, 16'(rc));
    rb = 1;
    repeat (14) @(negedge clk);
    chk("blank", 16'h0000, lit);
    chk("rc", 16'h0000, 16'(rc));
    rb = 0;
    repeat (12) @(negedge clk);
    scroll(0);
    complete_run();
  end
endmodule
